// ==== src/usb_dma_pkg.sv ====
// package: register map, field layout and types of the endpoint dma engine
package usb_dma_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0]  IDX_CTRL       = 8'hEA;
  localparam logic [7:0]  IDX_ADDR_LOW   = 8'hEB;
  localparam logic [7:0]  IDX_ADDR_HIGH  = 8'hEC;
  localparam logic [7:0]  IDX_COUNT      = 8'hED;
  localparam int          ADDR_W         = 14;
  localparam int          COUNT_W        = 7;
  localparam int          EP_OFS_W       = 7;
  // control register fields
  localparam int          CTRL_RUN_BIT   = 0;
  localparam int          CTRL_DIR_BIT   = 1;
  localparam int          CTRL_ERR_BIT   = 2;
  localparam int          CTRL_EPS_LSB   = 4;
  localparam int          CTRL_EPS_MSB   = 6;
  localparam int          ADDR_HIGH_W    = ADDR_W - 8;
  // reset values
  localparam logic [ADDR_W-1:0]  ADDR_RESET  = 14'h0100;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 7'h00;
  // ram window the engine may touch
  localparam logic [ADDR_W:0]    WIN_LOW     = 15'h0100;
  localparam logic [ADDR_W:0]    WIN_HIGH    = 15'h10FF;
  // endpoint selection and capacities
  localparam logic [2:0]  EPS_MAX_LEGAL  = 3'h4;
  localparam logic [7:0]  CAP_SINGLE     = 8'h40;
  localparam logic [7:0]  CAP_DOUBLE     = 8'h80;
  localparam logic [7:0]  CAP_SMALL      = 8'h08;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_START,
    ST_MOVE
  } dma_state_t;

  // request to the data ram (synchronous read, one cycle latency)
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
    logic              we;
    logic              re;
  } ram_req_t;

  // request to the endpoint buffer ram (synchronous read, one cycle latency)
  typedef struct packed {
    logic [2:0]          ep;
    logic [EP_OFS_W-1:0] offset;
    logic [7:0]          wdata;
    logic                we;
    logic                re;
  } ep_req_t;
endpackage

// ==== src/usb_endpoint_dma.sv ====
// usb endpoint dma engine: apb registers, launch checks and byte mover
//
// Function
// - a block of N bytes moves in at most N plus one clocks
// - processor is stalled during a transfer and resumes afterwards without polling
// - control bits 6..4 pick one of five endpoint buffers
// - endpoint capacities 64, 2x64, 2x64, 64, then 8 bytes; count limited by them
// - zero byte count or endpoint select above four is a violation
// - launch with good values clears error bit 2; software may clear it
// - error set when base address lies outside 0x0100 to 0x10FF
// - error set when base plus count runs past the ram window
// - error set when count exceeds the selected endpoint capacity
// - on error no transfer, registers kept, security violation raised
// - error flag with usb interrupts enabled drives the usb interrupt
// - direction bit 1: one sends ram to endpoint, zero receives
// - software writes run bit 0 to start; hardware clears it at end
// - a running transfer always completes, nothing aborts it
// - 14-bit ram address split high/low, resets to 0x0100
// - after a transfer the address holds last address plus one
// - byte count is 7 bits and survives a transfer
// - registers are unreachable while the usb module is disabled
// - reserved control bits and unused upper bits read zero
`timescale 1ns/1ps
module usb_endpoint_dma
  import usb_dma_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic             pready_o,
  output logic [31:0]      prdata_o,
  output logic             pslverr_o,
  input  wire logic        usb_enable_i,
  input  wire logic        usb_int_enable_i,
  output logic             usb_irq_o,
  output logic             security_violation_o,
  output logic             cpu_stall_o,
  output ram_req_t         ram_req_o,
  input  wire logic [7:0]  ram_rdata_i,
  output ep_req_t          ep_req_o,
  input  wire logic [7:0]  ep_rdata_i
);

  // capacity of each endpoint buffer in bytes
  function automatic logic [7:0] ep_capacity(input logic [2:0] eps);
    logic [7:0] cap;
    cap = CAP_SMALL;
    if (eps == 3'h1 || eps == 3'h2) begin
      cap = CAP_DOUBLE;
    end else if (eps == 3'h0 || eps == 3'h3) begin
      cap = CAP_SINGLE;
    end
    return cap;
  endfunction

  // all launch checks in one place; true means the launch is refused
  function automatic logic launch_bad(input logic [ADDR_W-1:0]  base,
                                      input logic [COUNT_W-1:0] cnt,
                                      input logic [2:0]         eps);
    logic [ADDR_W:0] last;
    logic            bad;
    last = {1'b0, base} + {{(ADDR_W+1-COUNT_W){1'b0}}, cnt} - 15'h0001;
    bad  = 1'b0;
    if (cnt == COUNT_RESET || eps > EPS_MAX_LEGAL) begin
      bad = 1'b1;
    end
    if ({1'b0, base} < WIN_LOW || {1'b0, base} > WIN_HIGH) begin
      bad = 1'b1;
    end else if (cnt != COUNT_RESET && last > WIN_HIGH) begin
      bad = 1'b1;
    end
    if ({1'b0, cnt} > ep_capacity(eps)) begin
      bad = 1'b1;
    end
    return bad;
  endfunction

  dma_state_t          state_q;
  logic [2:0]          eps_q;
  logic                dir_q;
  logic                err_q;
  logic                run_q;
  logic [ADDR_W-1:0]   addr_q;
  logic [COUNT_W-1:0]  count_q;
  logic [COUNT_W-1:0]  idx_q;
  logic                viol_q;
  logic                busy;
  logic                bad;
  logic                last_byte;
  logic                done;
  logic                acc;
  logic                wr_en;
  logic [7:0]          reg_idx;
  logic                mapped;
  logic [7:0]          rd_byte;

  assign busy      = (state_q != ST_IDLE);
  assign bad       = launch_bad(addr_q, count_q, eps_q);
  assign last_byte = (idx_q == count_q - 7'h01);
  assign done      = (state_q == ST_MOVE) && last_byte;

  // apb decode: registers sit at four times their index
  assign acc     = psel_i && penable_i;
  assign reg_idx = paddr_i[9:2];
  assign mapped  = (paddr_i[1:0] == 2'b00) && (paddr_i[31:10] == 22'h000000) &&
                   (reg_idx >= IDX_CTRL) && (reg_idx <= IDX_COUNT);
  // the stalled processor cannot finish an access until the copy is over
  assign pready_o  = !busy;
  assign wr_en     = acc && pready_o && pwrite_i && mapped && usb_enable_i;
  assign pslverr_o = acc && (!mapped || !usb_enable_i);
  assign cpu_stall_o = busy || run_q;

  // read mux; unused and reserved bits are zero
  always_comb begin
    rd_byte = 8'h00;
    unique case (reg_idx)
      IDX_CTRL: begin
        rd_byte[CTRL_EPS_MSB:CTRL_EPS_LSB] = eps_q;
        rd_byte[CTRL_ERR_BIT] = err_q;
        rd_byte[CTRL_DIR_BIT] = dir_q;
        rd_byte[CTRL_RUN_BIT] = run_q;
      end
      IDX_ADDR_LOW:  rd_byte = addr_q[7:0];
      IDX_ADDR_HIGH: rd_byte = {2'b00, addr_q[ADDR_W-1:8]};
      IDX_COUNT:     rd_byte = {1'b0, count_q};
      default:       rd_byte = 8'h00;
    endcase
  end
  // a disabled module or unmapped address reads as zero
  assign prdata_o = (acc && mapped && usb_enable_i) ? {24'h000000, rd_byte} : 32'h00000000;

  // endpoint select and direction are plain software fields
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      eps_q <= 3'h0;
      dir_q <= 1'b0;
    end else if (wr_en && reg_idx == IDX_CTRL) begin
      eps_q <= pwdata_i[CTRL_EPS_MSB:CTRL_EPS_LSB];
      dir_q <= pwdata_i[CTRL_DIR_BIT];
    end
  end

  // run bit: set by software, cleared by hardware at end or refusal
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      run_q <= 1'b0;
    end else if (wr_en && reg_idx == IDX_CTRL && pwdata_i[CTRL_RUN_BIT]) begin
      run_q <= 1'b1;
    end else if (done || (state_q == ST_START && bad)) begin
      run_q <= 1'b0;
    end
  end

  // error flag: launch check decides; software may only clear it
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      err_q <= 1'b0;
    end else if (state_q == ST_START) begin
      err_q <= bad;
    end else if (wr_en && reg_idx == IDX_CTRL && !pwdata_i[CTRL_ERR_BIT]) begin
      err_q <= 1'b0;
    end
  end

  // level interrupt until software clears the flag
  assign usb_irq_o = err_q && usb_int_enable_i;

  // one-cycle security violation on a refused launch
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      viol_q <= 1'b0;
    end else begin
      viol_q <= (state_q == ST_START) && bad;
    end
  end
  assign security_violation_o = viol_q;

  // address register: software writes, advances to end after a copy
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      addr_q <= ADDR_RESET;
    end else if (done) begin
      addr_q <= addr_q + {{(ADDR_W-COUNT_W){1'b0}}, count_q};
    end else if (wr_en && reg_idx == IDX_ADDR_LOW) begin
      addr_q[7:0] <= pwdata_i[7:0];
    end else if (wr_en && reg_idx == IDX_ADDR_HIGH) begin
      addr_q[ADDR_W-1:8] <= pwdata_i[ADDR_HIGH_W-1:0];
    end
  end

  // byte count is never touched by the engine itself
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      count_q <= COUNT_RESET;
    end else if (wr_en && reg_idx == IDX_COUNT) begin
      count_q <= pwdata_i[COUNT_W-1:0];
    end
  end

  // sequencer: start cycle checks and issues first read, then a byte a clock
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      idx_q   <= 7'h00;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          idx_q <= 7'h00;
          if (wr_en && reg_idx == IDX_CTRL && pwdata_i[CTRL_RUN_BIT]) begin
            state_q <= ST_START;
          end
        end
        ST_START: begin
          // a refused launch moves nothing and keeps the registers
          state_q <= bad ? ST_IDLE : ST_MOVE;
        end
        ST_MOVE: begin
          // no abort path exists: the processor cannot ask for one
          idx_q <= idx_q + 7'h01;
          if (last_byte) begin
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // memory strobes: read at idx+1 while writing idx, ascending addresses
  always_comb begin
    logic [COUNT_W-1:0] rd_idx;
    logic               rd_on;
    logic               wr_on;
    rd_idx = 7'h00;
    rd_on  = 1'b0;
    wr_on  = (state_q == ST_MOVE);
    if (state_q == ST_START) begin
      rd_on  = !bad;
      rd_idx = 7'h00;
    end else if (state_q == ST_MOVE && !last_byte) begin
      rd_on  = 1'b1;
      rd_idx = idx_q + 7'h01;
    end
    ram_req_o = '0;
    ep_req_o  = '0;
    ep_req_o.ep = eps_q;
    if (dir_q) begin
      // transmit: ram is read, endpoint buffer written
      ram_req_o.addr   = addr_q + {{(ADDR_W-COUNT_W){1'b0}}, rd_on ? rd_idx : idx_q};
      ram_req_o.re     = rd_on;
      ep_req_o.offset  = idx_q;
      ep_req_o.wdata   = ram_rdata_i;
      ep_req_o.we      = wr_on;
    end else begin
      // receive: endpoint buffer is read, ram written
      ep_req_o.offset  = rd_on ? rd_idx : idx_q;
      ep_req_o.re      = rd_on;
      ram_req_o.addr   = addr_q + {{(ADDR_W-COUNT_W){1'b0}}, idx_q};
      ram_req_o.wdata  = ep_rdata_i;
      ram_req_o.we     = wr_on;
    end
  end

  // helper: cycles since launch, read only by checks below
  logic [7:0] cyc_q;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || state_q == ST_IDLE) begin
      cyc_q <= 8'h00;
    end else begin
      cyc_q <= cyc_q + 8'h01;
    end
  end

  property p_len;
    @(posedge clk_sys_i) disable iff (rst_i)
      done |-> (cyc_q == {1'b0, count_q});
  endproperty
  a_len: assert property (p_len) else $error("transfer length wrong");

  property p_stall;
    @(posedge clk_sys_i) disable iff (rst_i)
      (state_q == ST_START && !bad) |-> cpu_stall_o [*2] ##1 (cpu_stall_o || !busy);
  endproperty
  a_stall: assert property (p_stall) else $error("processor not stalled");

  property p_refuse;
    @(posedge clk_sys_i) disable iff (rst_i)
      (state_q == ST_START && bad) |=> err_q && !run_q && security_violation_o &&
                                      $stable(addr_q) && $stable(count_q) &&
                                      state_q == ST_IDLE && !ram_req_o.we && !ep_req_o.we;
  endproperty
  a_refuse: assert property (p_refuse) else $error("bad launch not refused");

  property p_err_clear;
    @(posedge clk_sys_i) disable iff (rst_i)
      (state_q == ST_START && !bad) |=> !err_q ##[1:128] !run_q;
  endproperty
  a_err_clear: assert property (p_err_clear) else $error("good launch left error");

  property p_irq;
    @(posedge clk_sys_i) disable iff (rst_i)
      (err_q && usb_int_enable_i) |-> usb_irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing");

  property p_addr_adv;
    @(posedge clk_sys_i) disable iff (rst_i)
      done |=> addr_q == $past(addr_q) + {{(ADDR_W-COUNT_W){1'b0}}, $past(count_q)};
  endproperty
  a_addr_adv: assert property (p_addr_adv) else $error("address not advanced");

  property p_count_kept;
    @(posedge clk_sys_i) disable iff (rst_i)
      done |=> $stable(count_q) && !run_q;
  endproperty
  a_count_kept: assert property (p_count_kept) else $error("count lost");

  property p_disabled;
    @(posedge clk_sys_i) disable iff (rst_i)
      (acc && !usb_enable_i) |-> pslverr_o && prdata_o == 32'h00000000 ##1
                                 ($stable(err_q) || busy);
  endproperty
  a_disabled: assert property (p_disabled) else $error("access while disabled");

  property p_seq;
    @(posedge clk_sys_i) disable iff (rst_i)
      (state_q == ST_MOVE && ram_req_o.re) |->
        ram_req_o.addr == addr_q + {7'h00, idx_q} + 14'h0001;
  endproperty
  a_seq: assert property (p_seq) else $error("ram reads not ascending");

  // a zero written to the flag bit clears it on the next cycle, even when the same write launches
  property p_sw_clear;
    @(posedge clk_sys_i) disable iff (rst_i)
      (wr_en && reg_idx == IDX_CTRL && !pwdata_i[CTRL_ERR_BIT]) |=> !err_q;
  endproperty
  a_sw_clear: assert property (p_sw_clear) else $error("flag not cleared");

  property p_launch;
    @(posedge clk_sys_i) disable iff (rst_i)
      (wr_en && reg_idx == IDX_CTRL && pwdata_i[CTRL_RUN_BIT]) |=>
        state_q == ST_START && cpu_stall_o && !pready_o;
  endproperty
  a_launch: assert property (p_launch) else $error("run write did not launch");

  // no strobe may ever leave the permitted ram window
  property p_window;
    @(posedge clk_sys_i) disable iff (rst_i)
      (ram_req_o.we || ram_req_o.re) |->
        {1'b0, ram_req_o.addr} >= WIN_LOW && {1'b0, ram_req_o.addr} <= WIN_HIGH;
  endproperty
  a_window: assert property (p_window) else $error("ram access outside window");

  property p_ep_room;
    @(posedge clk_sys_i) disable iff (rst_i)
      (ep_req_o.we || ep_req_o.re) |-> {1'b0, ep_req_o.offset} < ep_capacity(ep_req_o.ep);
  endproperty
  a_ep_room: assert property (p_ep_room) else $error("endpoint offset too large");

  property p_legal_move;
    @(posedge clk_sys_i) disable iff (rst_i)
      (state_q == ST_MOVE) |-> eps_q <= EPS_MAX_LEGAL && count_q != COUNT_RESET;
  endproperty
  a_legal_move: assert property (p_legal_move) else $error("illegal launch moved");

  property p_no_abort;
    @(posedge clk_sys_i) disable iff (rst_i)
      (state_q == ST_MOVE && !last_byte) |=>
        state_q == ST_MOVE && idx_q == $past(idx_q) + 7'h01;
  endproperty
  a_no_abort: assert property (p_no_abort) else $error("transfer cut short");

  // exactly one side is written per moving cycle, chosen by direction
  property p_one_write;
    @(posedge clk_sys_i) disable iff (rst_i)
      (state_q == ST_MOVE) |-> (dir_q ? (ep_req_o.we && !ram_req_o.we) :
                                        (ram_req_o.we && !ep_req_o.we));
  endproperty
  a_one_write: assert property (p_one_write) else $error("wrong side written");

  c_tx:  cover property (@(posedge clk_sys_i) disable iff (rst_i) done && dir_q);
  c_rx:  cover property (@(posedge clk_sys_i) disable iff (rst_i) done && !dir_q);
  c_bad: cover property (@(posedge clk_sys_i) disable iff (rst_i) security_violation_o);
  c_irq: cover property (@(posedge clk_sys_i) disable iff (rst_i) usb_irq_o);
  c_off: cover property (@(posedge clk_sys_i) disable iff (rst_i) acc && !usb_enable_i);
endmodule

// ==== verification/dma_mem_model.sv ====
// data ram and endpoint buffer model with one cycle read latency
`timescale 1ns/1ps
module dma_mem_model
  import usb_dma_pkg::*;
(
  input  wire logic     clk_sys_i,
  input  wire ram_req_t ram_req_i,
  output logic [7:0]    ram_rdata_o,
  input  wire ep_req_t  ep_req_i,
  output logic [7:0]    ep_rdata_o
);
  logic [7:0] ram [0:16383];
  logic [7:0] epb [0:1023];
  int         oob = 0;
  initial ram_rdata_o = 8'hA5;
  initial ep_rdata_o = 8'h5A;
  // ram port; idle cycles show the inverse byte so stale data never looks valid
  always @(posedge clk_sys_i) begin
    if (ram_req_i.we) ram[ram_req_i.addr] <= ram_req_i.wdata;
    ram_rdata_o <= ram_req_i.re ? ram[ram_req_i.addr] : ~ram_rdata_o;
    if ((ram_req_i.we || ram_req_i.re) && (ram_req_i.addr < 14'h0100 ||
        ram_req_i.addr > 14'h10FF)) oob <= oob + 1;
  end
  // endpoint buffer port, indexed by endpoint then offset
  always @(posedge clk_sys_i) begin
    if (ep_req_i.we) epb[{ep_req_i.ep, ep_req_i.offset}] <= ep_req_i.wdata;
    ep_rdata_o <= ep_req_i.re ? epb[{ep_req_i.ep, ep_req_i.offset}] : ~ep_rdata_o;
  end
endmodule

// ==== verification/tb_top.sv ====
// bench: apb register access, launch checks, copied data and counts
`timescale 1ns/1ps
module tb_top;
  import usb_dma_pkg::*;
  logic        clk_sys_i = 0, rst_i = 1, psel = 0, pen = 0, pwr = 0, usb_en = 1, int_en = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata;
  logic        pready, pslverr, irq, sec, stall;
  ram_req_t    ram_req;
  ep_req_t     ep_req;
  logic [7:0]  ram_rd, ep_rd;
  int          err_total = 0, check_count = 0, sec_cnt = 0, seed = 32'heab79d8e;
  int          tbl [9][4] = '{'{0, 1, 'h100, 64}, '{1, 0, 'h140, 127}, '{4, 1, 'h10F8, 8},
    '{5, 1, 'h200, 4}, '{0, 0, 'h300, 0}, '{2, 1, 'h10FF, 2}, '{3, 0, 'h0FF, 1},
    '{4, 0, 'h400, 9}, '{0, 1, 'h1100, 1}};
  always #2 clk_sys_i = ~clk_sys_i;
  // violation pulses last one cycle, so count them as they pass
  always @(posedge clk_sys_i) if (sec === 1'b1) sec_cnt <= sec_cnt + 1;
  usb_endpoint_dma dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
    .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr), .usb_enable_i(usb_en),
    .usb_int_enable_i(int_en), .usb_irq_o(irq), .security_violation_o(sec),
    .cpu_stall_o(stall), .ram_req_o(ram_req), .ram_rdata_i(ram_rd), .ep_req_o(ep_req),
    .ep_rdata_i(ep_rd));
  dma_mem_model mem_u (.clk_sys_i(clk_sys_i), .ram_req_i(ram_req), .ram_rdata_o(ram_rd),
    .ep_req_i(ep_req), .ep_rdata_o(ep_rd));

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  // one apb transfer; the bench waits on pready, never on a fixed count
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int i;
    @(posedge clk_sys_i);
    psel <= 1; pen <= 0; pwr <= w; paddr <= {22'h0, idx, 2'h0}; pwdata <= d;
    @(posedge clk_sys_i) pen <= 1;
    for (i = 0; i < 400; i++) begin
      @(posedge clk_sys_i);
      if (pready === 1'b1) break;
    end
    r = prdata;
    e = pslverr;
    psel <= 0; pen <= 0;
    if (i == 400) begin
      chk("pready_wait", 1, 0);
      final_report;
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1, idx, d, r, e);
  endtask
  task automatic rchk(input logic [7:0] idx, input logic [31:0] exp, input logic ee,
                      input string nm);
    logic [31:0] r;
    logic        e;
    apb(0, idx, 0, r, e);
    chk(nm, exp, r);
    chk("pslverr", ee, e);
  endtask
  function automatic int cap(int e);
    return (e == 0 || e == 3) ? 64 : (e < 3 ? 128 : 8);
  endfunction
  function automatic bit bad(int e, int a, int n);
    return n == 0 || e > 4 || a < 'h100 || a + n > 'h1100 || n > cap(e);
  endfunction
  // one launch: program, run, then compare registers, flags and moved bytes
  task automatic run_case(input int e, input int d, input int a, input int n, input bit ie);
    int         c, k, x;
    logic       b;
    logic [7:0] ex [0:127];
    b = bad(e, a, n & 127);
    c = sec_cnt;
    int_en <= ie;
    for (k = 0; k < 128; k++) begin
      mem_u.epb[e * 128 + k] = $random(seed);
      mem_u.ram[(a + k) & 16383] = $random(seed);
      ex[k] = d ? mem_u.ram[(a + k) & 16383] : mem_u.epb[e * 128 + k];
    end
    wr(IDX_ADDR_LOW, a & 'hFF);
    wr(IDX_ADDR_HIGH, a >> 8);
    wr(IDX_COUNT, n);
    wr(IDX_CTRL, e * 16 + d * 2 + 5);
    k = 0;
    do begin
      @(posedge clk_sys_i);
      k++;
    end while (stall === 1'b1 && k < 300);
    chk("stall_cycles", 1, k > 1 && (b ? k == 2 : k <= (n & 127) + 2));
    if (k >= 300) begin
      chk("stall_wait", 1, 0);
      final_report;
    end
    x = b ? a : a + n;
    rchk(IDX_CTRL, e * 16 + d * 2 + (b ? 4 : 0), 0, "ctrl");
    rchk(IDX_ADDR_LOW, x & 'hFF, 0, "addr_low");
    rchk(IDX_ADDR_HIGH, (x >> 8) & 'h3F, 0, "addr_high");
    rchk(IDX_COUNT, n & 'h7F, 0, "count");
    chk("irq", b & ie, irq);
    chk("violation", b, sec_cnt - c);
    for (k = 0; k < n && !b; k++) begin
      chk("ep_byte", ex[k], mem_u.epb[e * 128 + k]);
      chk("ram_byte", ex[k], mem_u.ram[a + k]);
    end
    if (b && n % 2) begin
      wr(IDX_CTRL, e * 16 + d * 2);
      rchk(IDX_CTRL, e * 16 + d * 2, 0, "sw_clear");
      chk("irq_clear", 0, irq);
    end
    $display("case ep %0d dir %0d addr %h count %0d done", e, d, a, n);
  endtask

  // main sequence: reset values, field widths, corners, random launches, gating
  initial begin
    int t;
    repeat (12) @(posedge clk_sys_i);
    rst_i <= 0;
    rchk(IDX_CTRL, 0, 0, "ctrl_rst");
    rchk(IDX_ADDR_LOW, 0, 0, "low_rst");
    rchk(IDX_ADDR_HIGH, 1, 0, "high_rst");
    rchk(IDX_COUNT, 0, 0, "count_rst");
    wr(IDX_ADDR_HIGH, 'hFF);
    rchk(IDX_ADDR_HIGH, 'h3F, 0, "high_width");
    wr(IDX_COUNT, 'hFF);
    rchk(IDX_COUNT, 'h7F, 0, "count_width");
    rchk(8'hEE, 0, 1, "unmapped");
    for (t = 0; t < 9; t++) run_case(tbl[t][0], tbl[t][1], tbl[t][2], tbl[t][3], 1);
    for (t = 0; t < 24; t++) run_case({$random(seed)} % 6, {$random(seed)} % 2,
      'hF0 + {$random(seed)} % 'h1020, {$random(seed)} % 129, $random(seed));
    wr(IDX_COUNT, 3);
    usb_en <= 0;
    rchk(IDX_COUNT, 0, 1, "gated_read");
    wr(IDX_COUNT, 9);
    usb_en <= 1;
    rchk(IDX_COUNT, 3, 0, "gated_write");
    chk("ram_window", 0, mem_u.oob);
    final_report;
  end
endmodule
